/* File: core/srr_top.sv */
// spi request routing: enable/select register, flags, irq and dma requests
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module srr_top
	import srr_pkg::*;
#(
	parameter int ADDR_W = 4
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// spi core side
	input  wire srr_flags_in_t     spiFlags,
	input  wire logic              spiRunning,
	// dma controller
	input  wire srr_dma_t          dmaAck,
	output srr_dma_t               dmaReq,
	// interrupt controller
	output logic                   irq
);

	logic [31:0] rse_r;
	logic [31:0] rse_nxt;
	srr_flags_t  flags_r;
	srr_flags_t  flags_nxt;
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] readdata_r;
	logic [31:0] readdata_nxt;

	// bus decode
	logic        wrAccept;
	logic [31:0] clrBits;
	logic [31:0] statWord;
	logic [3:0]  addrLow;

	// routed requests, {irq, dma} per fill or drain flag
	logic [1:0]  txFfRoute;
	logic [1:0]  rxDfRoute;
	// interrupt sources: underflow, fill, overflow, drain
	logic [3:0]  irqSrc;
	logic        txUfIrq;
	logic        rxOfIrq;

	// place held flags at their status positions
	function automatic logic [31:0] flagWord(input srr_flags_t f);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[SRR_B_TXUF_EN] = f.txUf;
		w[SRR_B_TXFF_EN] = f.txFf;
		w[SRR_B_RXOF_EN] = f.rxOf;
		w[SRR_B_RXDF_EN] = f.rxDf;
		return w;
	endfunction

	// interrupt-only source: flag gated by its enable
	function automatic logic irqGate(
		input logic flag,
		input logic en
	);
		return flag & en;
	endfunction

	// fill or drain source: {irq, dma}; select 0 irq, 1 dma, never both
	function automatic logic [1:0] routeReq(
		input logic flag,
		input logic en,
		input logic sel
	);
		logic on;
		on = flag & en;
		return {on & ~sel, on & sel};
	endfunction

	// next value of one sticky flag; a set beats a clear in one cycle
	function automatic logic nextFlag(
		input logic held,
		input logic setEvt,
		input logic clrEvt
	);
		logic v;
		v = held;
		if (clrEvt)
		begin
			v = 1'b0;
		end
		if (setEvt)
		begin
			v = 1'b1;
		end
		return v;
	endfunction

	assign addrLow  = address[3:0];
	assign statWord = flagWord(flags_r);

	// bus handshake: one wait cycle, answer on the next edge
	always_comb
	begin
		ack_nxt      = 1'b0;
		readdata_nxt = readdata_r;
		if ((read | write) && !ack_r)
		begin
			ack_nxt = 1'b1;
		end
		if (read && !ack_r)
		begin
			unique case (addrLow)
				SRR_OFS_RSE:
				begin
					// reserved positions always read zero
					readdata_nxt = rse_r & SRR_RSE_MASK;
				end
				SRR_OFS_STAT:
				begin
					readdata_nxt = statWord;
				end
				default:
				begin
					// clear word and unmapped offsets
					readdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ack_r <= 1'b0;
		end
		else
		begin
			ack_r <= ack_nxt;
		end
	end

	// read data stands until the next read answer
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			readdata_r <= 32'h0000_0000;
		end
		else
		begin
			readdata_r <= readdata_nxt;
		end
	end

	assign waitrequest = (read | write) & ~ack_r;
	assign readdata    = readdata_r;
	assign wrAccept    = write & ack_r;

	// enable/select register
	always_comb
	begin
		rse_nxt = rse_r;
		// writes during a running transfer are dropped
		if (wrAccept && addrLow == SRR_OFS_RSE && !spiRunning)
		begin
			rse_nxt = writedata & SRR_RSE_MASK;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rse_r <= SRR_RSE_RST;
		end
		else
		begin
			rse_r <= rse_nxt;
		end
	end

	// write-one-to-clear, through status or clear offset
	always_comb
	begin
		clrBits = 32'h0000_0000;
		if (wrAccept)
		begin
			unique case (addrLow)
				SRR_OFS_STAT,
				SRR_OFS_CLR:
				begin
					clrBits = writedata & SRR_STAT_MASK;
				end
				default:
				begin
					clrBits = 32'h0000_0000;
				end
			endcase
		end
	end

	// sticky flags; a set in the clearing cycle wins
	always_comb
	begin
		flags_nxt      = flags_r;
		flags_nxt.txUf = nextFlag(flags_r.txUf, spiFlags.txUnderflowEvt,
			clrBits[SRR_B_TXUF_EN]);
		flags_nxt.rxOf = nextFlag(flags_r.rxOf, spiFlags.rxOverflowEvt,
			clrBits[SRR_B_RXOF_EN]);
		// fill flag is set while the tx fifo is not full and held; w1 or dma ack clear it
		flags_nxt.txFf = nextFlag(flags_r.txFf, spiFlags.txFifoNotFull,
			clrBits[SRR_B_TXFF_EN] | dmaAck.txFill);
		// drain flag clears only once the rx fifo is empty
		flags_nxt.rxDf = nextFlag(flags_r.rxDf, spiFlags.rxFifoNotEmpty,
			clrBits[SRR_B_RXDF_EN] | dmaAck.rxDrain);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			flags_r <= SRR_FLAG_RST;
		end
		else
		begin
			flags_r <= flags_nxt;
		end
	end

	// request routing; outputs follow the registers in the same cycle
	always_comb
	begin
		txUfIrq = irqGate(flags_r.txUf,
			rse_r[SRR_B_TXUF_EN]);
		rxOfIrq = irqGate(flags_r.rxOf,
			rse_r[SRR_B_RXOF_EN]);
		txFfRoute = routeReq(flags_r.txFf, rse_r[SRR_B_TXFF_EN],
			rse_r[SRR_B_TXFF_SEL]);
		rxDfRoute = routeReq(flags_r.rxDf, rse_r[SRR_B_RXDF_EN],
			rse_r[SRR_B_RXDF_SEL]);
		irqSrc = {txUfIrq, txFfRoute[1], rxOfIrq, rxDfRoute[1]};
	end

	assign dmaReq.txFill  = txFfRoute[0];
	assign dmaReq.rxDrain = rxDfRoute[0];
	// one level line for all enabled interrupt sources
	assign irq            = |irqSrc;

endmodule // srr_top

/* File: core/srr_pkg.sv */
// constants and types of the spi request routing block
package srr_pkg;

	// register byte offsets
	localparam logic [3:0] SRR_OFS_RSE   = 4'h0;
	localparam logic [3:0] SRR_OFS_STAT  = 4'h4;
	localparam logic [3:0] SRR_OFS_CLR   = 4'h8;

	// field positions; the _EN positions are shared by enable, status and clear words, the _SEL positions are in the enable word only
	localparam int SRR_B_TXUF_EN  = 27;
	localparam int SRR_B_TXFF_EN  = 25;
	localparam int SRR_B_TXFF_SEL = 24;
	localparam int SRR_B_RXOF_EN  = 19;
	localparam int SRR_B_RXDF_EN  = 17;
	localparam int SRR_B_RXDF_SEL = 16;

	// writable bits of request_select_enable
	localparam logic [31:0] SRR_RSE_MASK  = 32'h0B0B_0000;
	// flag bits of the status word
	localparam logic [31:0] SRR_STAT_MASK = 32'h0A0A_0000;
	// values after reset
	localparam logic [31:0] SRR_RSE_RST   = 32'h0000_0000;
	localparam logic [3:0]  SRR_FLAG_RST  = 4'h0;

	// cycles from request accept to answer
	localparam int SRR_ANSWER_CYC = 1;

	// flag inputs from the spi core
	typedef struct packed {
		logic txUnderflowEvt;
		logic txFifoNotFull;
		logic rxOverflowEvt;
		logic rxFifoNotEmpty;
	} srr_flags_in_t;

	// dma request or acknowledge pair
	typedef struct packed {
		logic txFill;
		logic rxDrain;
	} srr_dma_t;

	// held flags: underflow, fill, overflow, drain
	typedef struct packed {
		logic txUf;
		logic txFf;
		logic rxOf;
		logic rxDf;
	} srr_flags_t;

endpackage

/* File: bench/srr_asserts.sv */
// port assertions for srr_top
`timescale 1ns/1ns
module srr_asserts
	import srr_pkg::*;
#(parameter int ADDR_W = 4)
(
	// bus, spi, irq, dma
	input wire logic clk, rstn, read, write, waitrequest, spiRunning, irq,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [31:0] writedata,
	input wire srr_flags_in_t spiFlags,
	input wire srr_dma_t dmaAck, dmaReq
);
	logic [31:0] rse_r;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			rse_r <= '0;
		else if (write && !waitrequest && !spiRunning && address == '0)
			rse_r <= writedata & SRR_RSE_MASK;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_wait_first: assert property ($rose(read || write) |-> waitrequest)
		else $error("no wait");
	a_wait_one: assert property (waitrequest |=> !waitrequest)
		else $error("long wait");
	a_txff_req: assert property (spiFlags.txFifoNotFull
		|=> dmaReq.txFill == (rse_r[25] && rse_r[24])) else $error("tx dma");
	a_rxdf_req: assert property (spiFlags.rxFifoNotEmpty
		|=> dmaReq.rxDrain == (rse_r[17] && rse_r[16])) else $error("rx dma");
	a_txff_gate: assert property (!rse_r[25] |-> !dmaReq.txFill)
		else $error("tx gate");
	a_rxdf_gate: assert property (!rse_r[17] |-> !dmaReq.rxDrain)
		else $error("rx gate");
	a_irq_quiet: assert property ((rse_r & 32'h0A0A0000) == '0
		|-> !irq) else $error("irq set");
	a_ack_clear: assert property (dmaAck.rxDrain
		&& !spiFlags.rxFifoNotEmpty |=> !dmaReq.rxDrain) else $error("ack");
endmodule // srr_asserts

/* File: bench/srr_dma_model.sv */
// dma controller model: acks a request held for LAT+1 cycles, on the edge after the count reaches LAT
`timescale 1ns/1ns
module srr_dma_model
	import srr_pkg::*;
#(parameter int LAT = 2)
(
	input wire logic clk, rstn,
	input wire srr_dma_t dmaReq,
	output srr_dma_t dmaAck
);
	int cnt_r;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			cnt_r <= 0;
			dmaAck <= '0;
		end
		else
		begin
			cnt_r <= (dmaReq != '0 && cnt_r < LAT) ? cnt_r + 1 : 0;
			dmaAck <= (cnt_r == LAT) ? dmaReq : '0;
		end
endmodule // srr_dma_model

/* File: bench/srr_top_bench.sv */
// self-checking bench for srr_top
`timescale 1ns/1ns
module srr_top_bench;
	import srr_pkg::*;
	logic clk = 0, rstn = 0, read = 0, write = 0, spiRunning = 0;
	logic waitrequest, irq;
	logic [3:0] address = '0;
	logic [31:0] writedata = '0, readdata, rd;
	srr_flags_in_t spiFlags = '0;
	srr_dma_t dmaAck, dmaReq;
	int err_total = 0, n_compared = 0;
	srr_top i_srr_top (.clk, .rstn, .address, .read, .write, .writedata,
		.readdata, .waitrequest, .spiFlags, .spiRunning, .dmaAck, .dmaReq, .irq);
	srr_dma_model i_srr_dma_model (.clk, .rstn, .dmaReq, .dmaAck);
	initial forever #50 clk = ~clk;
	task chk(string s, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s: %h, seen %h", s, e, g);
		end
	endtask
	task bus(logic w, logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		write <= w;
		read <= !w;
		address <= a;
		writedata <= d;
		do @(negedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		@(posedge clk);
		write <= 0;
		read <= 0;
	endtask
	task irqs(logic [31:0] en, srr_flags_in_t f, logic [2:0] e);
		bus(1, 4'h0, en);
		@(posedge clk) spiFlags <= f;
		@(posedge clk) spiFlags <= '0;
		@(negedge clk) chk("req", e, {irq, dmaReq});
		bus(0, 4'h4, 0);
		chk("stat", {4'h0, f[3], 1'h0, f[2], 5'h00, f[1], 1'h0, f[0],
			17'h0_0000}, rd);
		bus(1, 4'h8, 32'h0A0A0000);
		@(posedge clk) @(negedge clk) chk("clr", 0, irq);
	endtask
	task reset_mid;
		bus(1, 4'h0, 32'h00080000);
		@(posedge clk) spiFlags <= 4'b0010;
		@(posedge clk) spiFlags <= '0;
		@(negedge clk) chk("pre rst irq", 1, irq);
		@(posedge clk) rstn <= 0;
		@(negedge clk) chk("rst irq", 0, irq);
		repeat (16) @(posedge clk);
		rstn <= 1;
		bus(0, 4'h0, 0);
		chk("rst rse", SRR_RSE_RST, rd);
		bus(0, 4'h4, 0);
		chk("rst stat", 0, rd);
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		err_total++;
		wrap_up;
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		bus(1, 4'h0, 32'hFFFFFFFF);
		bus(0, 4'h0, 0);
		chk("rse", 32'h0B0B0000, rd);
		bus(0, 4'hC, 0);
		chk("unmapped", 0, rd);
		spiRunning <= 1;
		bus(1, 4'h0, 0);
		spiRunning <= 0;
		bus(0, 4'h0, 0);
		chk("rse run", 32'h0B0B0000, rd);
		irqs(32'h08000000, 4'b1000, 3'b100);
		irqs(32'h00000000, 4'b1000, 3'b000);
		irqs(32'h00080000, 4'b0010, 3'b100);
		irqs(32'h08000000, 4'b0010, 3'b000);
		irqs(32'h02000000, 4'b0100, 3'b100);
		irqs(32'h03000000, 4'b0100, 3'b010);
		irqs(32'h01000000, 4'b0100, 3'b000);
		irqs(32'h00020000, 4'b0001, 3'b100);
		irqs(32'h00030000, 4'b0001, 3'b001);
		irqs(32'h00010000, 4'b0001, 3'b000);
		reset_mid;
		wrap_up;
	end
endmodule // srr_top_bench
bind srr_top srr_asserts #(.ADDR_W(ADDR_W)) i_srr_asserts (.clk, .rstn,
	.read, .write, .waitrequest, .spiRunning, .irq, .address, .writedata,
	.spiFlags, .dmaAck, .dmaReq);
